//--- hdl/pxc_prox_config.sv
// Proximity and auxiliary conversion configuration registers and the
// proximity recovery / integration timer feeding the ADC sequencer.
// Assumes a synchronous register port and one-cycle conversion requests.
//
// Summary of operation
// - Recovery delay 1,7..511 ADC clocks from code
// - ADC clock period is 50 ns
// - Integration and emitter pulse scale by 2^code
// - Scaling divides ADC clock by 2^code
// - Sequencer never rejects any programmed combination
// - Range bit selects normal or high range
// - Mode bit selects raw or proximity mode
// - Raw mode keeps all emitters off
// - Ambient IR input selector 0x00 small, 0x03 large
// - Auxiliary selector 0x65 temperature, 0x75 supply
`timescale 1ns/10ps
`default_nettype none
module pxc_prox_config import pxc_pkg::*; #(
	parameter int INTEG_BASE = PXC_INTEG_BASE_ADC_CLKS,
	parameter int TICK_CYCLES = PXC_ADC_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire pxc_bus_req_t bus_i,
	output logic [7:0] rd_data_o,
	input wire logic prox_start_i,
	output logic prox_busy_o,
	output logic prox_integrating_o,
	output logic infrared_emitter_en_o,
	output logic adc_sample_tick_o,
	output logic prox_done_o,
	output var pxc_cfg_t cfg_o
);

	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	typedef struct packed {
		pxc_cfg_t cfg;
		pxc_phase_t phase;
		logic [15:0] cnt;
		logic busy;
		logic integrating;
		logic emitter;
		logic sample_tick;
		logic done;
		logic [7:0] rd_data;
	} pxc_core_t;

	pxc_core_t q;
	pxc_core_t next_q;
	logic adc_tick;
	logic div_tick;
	logic restart;

	function automatic logic [9:0] pxc_rec_clks(input logic [2:0] code);
		if (code == 3'h0) begin
			pxc_rec_clks = 10'h001;
		end else begin
			pxc_rec_clks = 10'((11'h004 << code) - 11'h001);
		end
	endfunction

	// -------------------------------------------------------------------
	// ADC clock and scaled divider
	// -------------------------------------------------------------------
	pxc_adc_divider #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.restart_i(restart),
		.scale_i(q.cfg.prox_integration_scale_code),
		.adc_tick_o(adc_tick),
		.div_tick_o(div_tick)
	);

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.sample_tick = 1'b0;
		next_q.rd_data = 8'h00;
		restart = 1'b0;

		// Register writes keep only defined fields; reserved bits drop
		if (bus_i.wr) begin
			if (bus_i.addr == PXC_OFS_RECOVERY) begin
				next_q.cfg.prox_recovery_code = bus_i.wdata[PXC_REC_LSB +: 3];
			end else if (bus_i.addr == PXC_OFS_SCALE) begin
				// Any code is taken; limiting to 5 is up to software
				next_q.cfg.prox_integration_scale_code = bus_i.wdata[PXC_SCALE_LSB +: 3];
			end else if (bus_i.addr == PXC_OFS_RANGE_MODE) begin
				next_q.cfg.prox_signal_range = bus_i.wdata[PXC_RANGE_BIT];
				next_q.cfg.prox_conversion_mode = bus_i.wdata[PXC_MODE_BIT];
			end else if (bus_i.addr == PXC_OFS_IR_SEL) begin
				next_q.cfg.ambient_ir_input_code = bus_i.wdata;
			end else if (bus_i.addr == PXC_OFS_AUX_SEL) begin
				next_q.cfg.auxiliary_input_code = bus_i.wdata;
			end
		end

		if (bus_i.rd) begin
			if (bus_i.addr == PXC_OFS_RECOVERY) begin
				next_q.rd_data = {1'b0, q.cfg.prox_recovery_code, 4'h0};
			end else if (bus_i.addr == PXC_OFS_SCALE) begin
				next_q.rd_data = {5'h00, q.cfg.prox_integration_scale_code};
			end else if (bus_i.addr == PXC_OFS_RANGE_MODE) begin
				next_q.rd_data = {2'h0, q.cfg.prox_signal_range, 2'h0, q.cfg.prox_conversion_mode, 2'h0};
			end else if (bus_i.addr == PXC_OFS_IR_SEL) begin
				next_q.rd_data = q.cfg.ambient_ir_input_code;
			end else if (bus_i.addr == PXC_OFS_AUX_SEL) begin
				next_q.rd_data = q.cfg.auxiliary_input_code;
			end
		end

		case (q.phase)
			PXC_IDLE: begin
				if (prox_start_i) begin
					restart = 1'b1;
					next_q.phase = PXC_RECOVER;
					next_q.cnt = 16'h0000;
					next_q.busy = 1'b1;
				end
			end
			PXC_RECOVER: begin
				if (adc_tick) begin
					if (q.cnt >= 16'(pxc_rec_clks(q.cfg.prox_recovery_code) - 10'h001)) begin
						restart = 1'b1;
						next_q.phase = PXC_INTEGRATE;
						next_q.cnt = 16'h0000;
						next_q.integrating = 1'b1;
						// Emitters stay dark in raw mode, no reference pulse
						next_q.emitter = q.cfg.prox_conversion_mode;
					end else begin
						next_q.cnt = q.cnt + 16'h0001;
					end
				end
			end
			PXC_INTEGRATE: begin
				if (div_tick) begin
					next_q.sample_tick = 1'b1;
					if (q.cnt >= 16'(INTEG_BASE - 1)) begin
						next_q.phase = PXC_IDLE;
						next_q.cnt = 16'h0000;
						next_q.busy = 1'b0;
						next_q.integrating = 1'b0;
						next_q.emitter = 1'b0;
						next_q.done = 1'b1;
					end else begin
						next_q.cnt = q.cnt + 16'h0001;
					end
				end
			end
			default: begin
				next_q.phase = PXC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.phase <= PXC_IDLE;
			q.cfg.prox_recovery_code <= PXC_RST_REC;
			q.cfg.prox_integration_scale_code <= PXC_RST_SCALE;
			q.cfg.prox_signal_range <= PXC_RST_RANGE;
			q.cfg.prox_conversion_mode <= PXC_RST_MODE;
			q.cfg.ambient_ir_input_code <= PXC_RST_IR_SEL;
			q.cfg.auxiliary_input_code <= PXC_RST_AUX_SEL;
		end else begin
			q <= next_q;
		end
	end

	assign rd_data_o = q.rd_data;
	assign prox_busy_o = q.busy;
	assign prox_integrating_o = q.integrating;
	assign infrared_emitter_en_o = q.emitter;
	assign adc_sample_tick_o = q.sample_tick;
	assign prox_done_o = q.done;
	assign cfg_o = q.cfg;

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	logic [15:0] chk_rec_ticks;
	logic [15:0] chk_int_ticks;
	logic [7:0] chk_adc_per_div;
	logic [7:0] chk_cyc_per_adc;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || q.phase == PXC_IDLE) begin
			chk_rec_ticks <= 16'h0000;
			chk_int_ticks <= 16'h0000;
			chk_adc_per_div <= 8'h00;
			chk_cyc_per_adc <= 8'h00;
		end else begin
			if (q.phase == PXC_RECOVER && adc_tick) begin
				chk_rec_ticks <= chk_rec_ticks + 16'h0001;
			end
			if (q.phase == PXC_INTEGRATE && div_tick) begin
				chk_int_ticks <= chk_int_ticks + 16'h0001;
			end
			if (q.phase != PXC_INTEGRATE || div_tick) begin
				chk_adc_per_div <= 8'h00;
			end else if (adc_tick) begin
				chk_adc_per_div <= chk_adc_per_div + 8'h01;
			end
			chk_cyc_per_adc <= (adc_tick || restart) ? 8'h00 : chk_cyc_per_adc + 8'h01;
		end
	end

	sequence seq_wr_misc;
		bus_i.wr && bus_i.addr == PXC_OFS_RANGE_MODE;
	endsequence

	sequence seq_start_idle;
		q.phase == PXC_IDLE && prox_start_i;
	endsequence

	recov_len_a: assert property (q.phase == PXC_RECOVER && next_q.phase == PXC_INTEGRATE
		|-> chk_rec_ticks + 16'h0001 == 16'(pxc_rec_clks(q.cfg.prox_recovery_code)))
		else $error("recovery length wrong");
	adc_period_a: assert property (adc_tick && q.phase != PXC_IDLE && !$past(restart)
		|-> chk_cyc_per_adc == 8'(TICK_CYCLES - 1))
		else $error("adc clock period wrong");
	integ_len_a: assert property (q.phase == PXC_INTEGRATE && next_q.phase == PXC_IDLE
		|-> chk_int_ticks + 16'h0001 == 16'(INTEG_BASE))
		else $error("integration length wrong");
	div_ratio_a: assert property (q.phase == PXC_INTEGRATE && div_tick
		|-> 9'(chk_adc_per_div) + 9'h001 == 9'(9'h001 << q.cfg.prox_integration_scale_code))
		else $error("scaled divider ratio wrong");
	start_taken_a: assert property (seq_start_idle |=> prox_busy_o ##1 prox_busy_o)
		else $error("conversion request not taken");
	range_write_a: assert property (seq_wr_misc ##1 !bus_i.wr
		|-> cfg_o.prox_signal_range == $past(bus_i.wdata[PXC_RANGE_BIT], 1))
		else $error("range bit not applied");
	raw_dark_a: assert property (!cfg_o.prox_conversion_mode && q.phase == PXC_RECOVER
		&& !(bus_i.wr && bus_i.addr == PXC_OFS_RANGE_MODE) |=> !infrared_emitter_en_o [*2])
		else $error("emitter on in raw mode");
	emitter_mode_a: assert property ($rose(prox_integrating_o)
		|-> infrared_emitter_en_o == $past(cfg_o.prox_conversion_mode))
		else $error("emitter does not follow mode");
	mux_write_a: assert property (bus_i.wr && (bus_i.addr == PXC_OFS_IR_SEL || bus_i.addr == PXC_OFS_AUX_SEL)
		|=> (cfg_o.ambient_ir_input_code == $past(bus_i.wdata)) || (cfg_o.auxiliary_input_code == $past(bus_i.wdata)))
		else $error("input selector not stored");
	rec_reserved_a: assert property (bus_i.rd && bus_i.addr == PXC_OFS_RECOVERY
		|=> rd_data_o[3:0] == 4'h0 && rd_data_o[7] == 1'b0)
		else $error("reserved recovery bits not zero");
	aux_reset_a: assert property ($fell(sys_rst_i) |-> cfg_o.auxiliary_input_code == PXC_RST_AUX_SEL)
		else $error("auxiliary selector reset wrong");

endmodule
`default_nettype wire

//--- common/pxc_pkg.sv
// Package for the proximity conversion configuration block: register map,
// field layout, reset values, timing figures and shared types.
// Assumes a single 40 MHz system clock and an 8-bit register port.
package pxc_pkg;

	// -------------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] PXC_OFS_RECOVERY = 8'h0a;
	localparam logic [7:0] PXC_OFS_SCALE = 8'h0b;
	localparam logic [7:0] PXC_OFS_RANGE_MODE = 8'h0c;
	localparam logic [7:0] PXC_OFS_IR_SEL = 8'h0e;
	localparam logic [7:0] PXC_OFS_AUX_SEL = 8'h0f;

	// -------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------
	localparam int PXC_REC_LSB = 4;
	localparam int PXC_SCALE_LSB = 0;
	localparam int PXC_RANGE_BIT = 5;
	localparam int PXC_MODE_BIT = 2;

	// -------------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------------
	localparam logic [2:0] PXC_RST_REC = 3'h0;
	localparam logic [2:0] PXC_RST_SCALE = 3'h0;
	localparam logic PXC_RST_RANGE = 1'b0;
	localparam logic PXC_RST_MODE = 1'b1;
	localparam logic [7:0] PXC_RST_IR_SEL = 8'h00;
	localparam logic [7:0] PXC_RST_AUX_SEL = 8'h65;

	// -------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------
	localparam int PXC_SYS_CLK_PS = 25000;
	localparam int PXC_ADC_CLK_NS = 50;
	localparam int PXC_ADC_TICK_CYCLES = (PXC_ADC_CLK_NS * 1000 + PXC_SYS_CLK_PS - 1) / PXC_SYS_CLK_PS;
	localparam int PXC_INTEG_BASE_ADC_CLKS = 512;

	// -------------------------------------------------------------------
	// Types
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		PXC_IDLE,
		PXC_RECOVER,
		PXC_INTEGRATE
	} pxc_phase_t;

	typedef struct packed {
		logic [2:0] prox_recovery_code;
		logic [2:0] prox_integration_scale_code;
		logic prox_signal_range;
		logic prox_conversion_mode;
		logic [7:0] ambient_ir_input_code;
		logic [7:0] auxiliary_input_code;
	} pxc_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pxc_bus_req_t;

endpackage

//--- hdl/pxc_adc_divider.sv
// ADC clock tick generator and scaled integration tick divider.
// Assumes restart_i is a one-cycle request from the sequencer.
`timescale 1ns/10ps
`default_nettype none
module pxc_adc_divider import pxc_pkg::*; #(
	parameter int TICK_CYCLES = PXC_ADC_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic restart_i,
	input wire logic [2:0] scale_i,
	output logic adc_tick_o,
	output logic div_tick_o
);

	typedef struct packed {
		logic [7:0] cyc;
		logic [6:0] div;
		logic adc_tick;
		logic div_tick;
	} pxc_div_state_t;

	pxc_div_state_t q;
	pxc_div_state_t next_q;

	function automatic logic [6:0] pxc_div_last(input logic [2:0] code);
		pxc_div_last = 7'((8'h01 << code) - 8'h01);
	endfunction

	always_comb begin
		next_q = q;
		next_q.adc_tick = 1'b0;
		next_q.div_tick = 1'b0;
		if (restart_i) begin
			// Realign phase; the restart cycle already counts, so the
			// first interval is one whole ADC clock and not one cycle more
			next_q.cyc = 8'h00;
			next_q.div = 7'h00;
		end
		if (next_q.cyc == 8'(TICK_CYCLES - 1)) begin
			next_q.cyc = 8'h00;
			next_q.adc_tick = 1'b1;
			if (next_q.div >= pxc_div_last(scale_i)) begin
				next_q.div = 7'h00;
				next_q.div_tick = 1'b1;
			end else begin
				next_q.div = next_q.div + 7'h01;
			end
		end else begin
			next_q.cyc = next_q.cyc + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign adc_tick_o = q.adc_tick;
	assign div_tick_o = q.div_tick;

endmodule
`default_nettype wire

//--- bench/pxc_host_model.sv
// Host processor model driving the configuration register port.
// Assumes the port never stalls and answers a read in the following cycle.
`timescale 1ns/10ps
`default_nettype none
module pxc_host_model import pxc_pkg::*; (
	input wire logic clk_i,
	input wire logic [7:0] rd_data_i,
	output var pxc_bus_req_t bus_o
);
	initial bus_o = '0;

	// Scale codes above 5 can overheat the emitters, so the host never sends them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == PXC_OFS_SCALE && v[2:0] > 3'h5) v[2:0] = 3'h5;
		@(posedge clk_i);
		bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk_i);
		bus_o <= '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		bus_o <= '0;
		@(negedge clk_i);
		d = rd_data_i;
	endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the proximity conversion configuration block.
// Assumes the package and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench import pxc_pkg::*; ;
	localparam int INTEG = 4;
	localparam int TICK = 2;
	localparam logic [15:0] DIRS [8] = '{16'h0e03, 16'h0e00, 16'h0f75, 16'h0f65,
		16'h0aff, 16'h0b07, 16'h0cff, 16'h0d5a};
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic prox_start_i = 1'b0;
	pxc_bus_req_t bus;
	logic [7:0] rd_data;
	logic busy, integ, emit, tick, done;
	pxc_cfg_t cfg;
	int n_errors = 0;
	int checks_done = 0;
	logic [31:0] lfsr = 32'h0001102c;
	logic [7:0] shadow [16];

	always #12.5 clk_i = ~clk_i;

	pxc_host_model i_host (.clk_i(clk_i), .rd_data_i(rd_data), .bus_o(bus));
	pxc_prox_config #(.INTEG_BASE(INTEG), .TICK_CYCLES(TICK)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.bus_i(bus), .rd_data_o(rd_data), .prox_start_i(prox_start_i), .prox_busy_o(busy),
		.prox_integrating_o(integ), .infrared_emitter_en_o(emit), .adc_sample_tick_o(tick),
		.prox_done_o(done), .cfg_o(cfg));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
		return lfsr;
	endfunction

	function automatic logic [7:0] expect_of(input logic [7:0] a, input logic [7:0] d);
		case (a)
			PXC_OFS_RECOVERY: return d & 8'h70;
			PXC_OFS_SCALE: return (d[2:0] > 3'h5) ? 8'h05 : {5'h00, d[2:0]};
			PXC_OFS_RANGE_MODE: return d & 8'h24;
			PXC_OFS_IR_SEL, PXC_OFS_AUX_SEL: return d;
			default: return 8'h00;
		endcase
	endfunction

	task automatic rst_shadow();
		shadow = '{default: 8'h00};
		shadow[12] = 8'h04;
		shadow[15] = 8'h65;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		i_host.wr(a, d);
		shadow[a[3:0]] = expect_of(a, d);
	endtask

	task automatic reg_chk(input logic [7:0] a);
		logic [7:0] d;
		i_host.rd(a, d);
		check(d, shadow[a[3:0]]);
	endtask

	task automatic cfg_chk();
		check(cfg.prox_recovery_code, shadow[10][6:4]);
		check(cfg.prox_integration_scale_code, shadow[11][2:0]);
		check(cfg.prox_signal_range, shadow[12][5]);
		check(cfg.prox_conversion_mode, shadow[12][2]);
		check(cfg.ambient_ir_input_code, shadow[14]);
		check(cfg.auxiliary_input_code, shadow[15]);
	endtask

	// A second start inside the conversion must be ignored
	task automatic conv(input logic [2:0] rc, input logic [2:0] sc, input logic md, output logic [31:0] t_rec);
		logic [31:0] cnt, first, last, nt, r;
		logic fin;
		r = rnd();
		reg_wr(PXC_OFS_RECOVERY, {1'b0, rc, 4'h0});
		reg_wr(PXC_OFS_SCALE, {5'h00, sc});
		reg_wr(PXC_OFS_RANGE_MODE, {2'b00, r[0], 2'b00, md, 2'b00});
		cnt = 0;
		nt = 0;
		first = 0;
		last = 0;
		t_rec = 0;
		fin = 1'b0;
		@(posedge clk_i);
		prox_start_i <= 1'b1;
		@(posedge clk_i);
		prox_start_i <= 1'b0;
		while (!fin && cnt < 20000) begin
			@(posedge clk_i);
			prox_start_i <= (cnt == 3);
			#1;
			cnt++;
			if (integ === 1'b1 && t_rec == 0) t_rec = cnt;
			if (tick === 1'b1) begin
				if (nt == 0) first = cnt;
				last = cnt;
				nt++;
			end
			check(emit, integ & md);
			fin = (done === 1'b1);
			if (!fin) check(busy, 1'b1);
		end
		if (!fin) begin
			n_errors++;
			close_out();
		end
		check(nt, INTEG);
		check(last - first, (INTEG - 1) * TICK * (1 << sc));
		repeat (3) @(posedge clk_i);
		#1;
		check(busy, 1'b0);
		check(done, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] t, t0, tr;
		rst_shadow();
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 9; i < 16; i++) reg_chk(8'(i));
		cfg_chk();
		foreach (DIRS[k]) begin
			reg_wr(DIRS[k][15:8], DIRS[k][7:0]);
			reg_chk(DIRS[k][15:8]);
			cfg_chk();
		end
		repeat (40) begin
			t = rnd();
			tr = rnd();
			reg_wr(8'h09 + 8'(t % 7), tr[7:0]);
			reg_chk(8'h09 + 8'(t % 7));
			cfg_chk();
		end
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rst_shadow();
		for (int i = 10; i < 16; i++) reg_chk(8'(i));
		cfg_chk();
		conv(3'h0, 3'h0, 1'b1, t0);
		for (int r = 0; r < 8; r++) begin
			conv(3'(r), 3'(r % 6), r[0], tr);
			check(tr - t0, TICK * ((r == 0) ? 0 : (4 << r) - 2));
		end
		close_out();
	end
endmodule
`default_nettype wire
